// file: rtl/ecppr_defs.svh
// offsets, field positions, reset values and timing counts of the port
`ifndef ECPPR_DEFS_SVH
`define ECPPR_DEFS_SVH
// register indices; byte address on the bus is four times the index
`define ECPPR_IDX_DATA     11'h000
`define ECPPR_IDX_STATUS   11'h001
`define ECPPR_IDX_CONTROL  11'h002
`define ECPPR_IDX_QUEUE    11'h400
`define ECPPR_IDX_CAPB     11'h401
`define ECPPR_IDX_ECR      11'h402
// control register fields
`define ECPPR_CTL_STROBE   0
`define ECPPR_CTL_FEED     1
`define ECPPR_CTL_INIT     2
`define ECPPR_CTL_SELIN    3
`define ECPPR_CTL_ACKIE    4
`define ECPPR_CTL_DIR      5
// extended control fields
`define ECPPR_ECR_MODE_HI  7
`define ECPPR_ECR_MODE_LO  5
`define ECPPR_ECR_ERRIE    4
`define ECPPR_ECR_DMA_ENABLE_BIT    3
`define ECPPR_ECR_SVC      2
// reset and fixed values
`define ECPPR_DATA_RST     8'h00
`define ECPPR_CTL_RST      6'h00
`define ECPPR_ECR_RST      8'h14
`define ECPPR_CAPA_VAL     8'h10
// queue geometry and service thresholds
`define ECPPR_Q_DEPTH      16
`define ECPPR_Q_CNT_W      5
`define ECPPR_FREE_LEVEL   5'h08
`define ECPPR_FILL_LEVEL   5'h08
// line timing
`define ECPPR_CLK_NS       10
`define ECPPR_PHASE_NS     500
`define ECPPR_PHASE_CYC \
   ((`ECPPR_PHASE_NS + `ECPPR_CLK_NS - 1) / `ECPPR_CLK_NS)
`endif

// file: rtl/ecppr_pkg.sv
// types shared by the parallel port register bank
package ecppr_pkg;
   // operating mode field of the extended control register
   typedef enum logic [2:0] {
      mode_compat = 3'h0,
      mode_bidir  = 3'h1,
      mode_compat_queue_port  = 3'h2,
      mode_ecp    = 3'h3,
      mode_epp    = 3'h4,
      mode_rsvd   = 3'h5,
      mode_test   = 3'h6,
      mode_config = 3'h7
   } ecppr_mode_e;
   // forward transmit sequencer, one-hot
   typedef enum logic [3:0] {
      tx_idle   = 4'h1,
      tx_setup  = 4'h2,
      tx_strobe = 4'h4,
      tx_hold   = 4'h8
   } ecppr_tx_e;
   // peripheral status inputs
   typedef struct packed {
      logic peripheral_fault_n;
      logic select_in;
      logic paper_error_in;
      logic peripheral_ack_n;
      logic busy_in;
   } ecppr_stat_s;
   // printer control outputs
   typedef struct packed {
      logic strobe_out_n;
      logic line_feed_out_n;
      logic printer_reset_out_n;
      logic select_request_out_n;
   } ecppr_ctl_s;
endpackage : ecppr_pkg

// file: rtl/ecppr_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module ecppr_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,   // system clock
   input  wire logic         nrst,  // async reset, active low
   input  wire logic [W-1:0] d,     // asynchronous pin levels
   output logic      [W-1:0] q      // synchronised levels
);
   logic [W-1:0] meta_q;
   // first stage feeds only the second
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_q <= '0;
         q      <= '0;
      end else begin
         meta_q <= d;
         q      <= meta_q;
      end
   end
endmodule : ecppr_sync

// file: rtl/ecppr_fifo.sv
// shared 16-entry byte queue with address tag bit
`timescale 1ns/1ps
`include "ecppr_defs.svh"
module ecppr_fifo (
   input  wire logic                     clk,   // system clock
   input  wire logic                     nrst,  // async reset, active low
   input  wire logic                     clr,   // synchronous flush
   input  wire logic                     push,  // store din
   input  wire logic [8:0]               din,   // tag and byte
   input  wire logic                     pop,   // drop head
   output logic      [8:0]               dout,  // head entry
   output logic                          full,  // no free entry
   output logic                          empty, // no entry
   output logic      [`ECPPR_Q_CNT_W-1:0] count // entries held
);
   logic [8:0] mem [`ECPPR_Q_DEPTH];
   logic [3:0] wr_q;
   logic [3:0] rd_q;
   logic       do_push;
   logic       do_pop;

   // a push when full and a pop when empty are dropped
   assign do_push = push & ~full;
   assign do_pop  = pop & ~empty;
   assign full    = (count == 5'h10);
   assign empty   = (count == 5'h00);
   assign dout    = mem[rd_q];

   // pointers and fill count
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wr_q  <= 4'h0;
         rd_q  <= 4'h0;
         count <= 5'h00;
      end else if (clr) begin
         wr_q  <= 4'h0;
         rd_q  <= 4'h0;
         count <= 5'h00;
      end else begin
         if (do_push) wr_q <= wr_q + 4'h1;
         if (do_pop)  rd_q <= rd_q + 4'h1;
         count <= count + {4'h0, do_push} - {4'h0, do_pop};
      end
   end

   // storage
   always_ff @(posedge clk) begin
      if (do_push) mem[wr_q] <= din;
   end
endmodule : ecppr_fifo

// file: rtl/ecppr_regs.sv
// parallel port register bank with mode decode and shared queue
//
// Summary of operation
// - decode offsets 0, 400h, 401h by mode
// - three-bit mode selects port personality
// - data register resets, latches, drives lines
// - data read returns live port line levels in modes 000, 001
// - ecp offset zero write queues address byte
// - status bits 0 to 2 read zero
// - status 3..6 show fault, select, paper, ack
// - status bit 7 is inverted busy
// - control bits 0..5 reset; 6,7 zero
// - strobe, feed, select inverted; init straight
// - ack rising edge raises irq when enabled
// - direction bit ignored in modes 000, 010
// - mode 010 queues bytes, sends by handshake
// - ecp mode sends forward, captures reverse bytes
// - test queue works without line handshake
// - test queue: drop on full, repeat on empty
// - test reads come from queue head, last byte read when empty
// - service flag sets on threshold, may interrupt
// - capability a reads 10h in mode 111
// - capability b bit 7 reads zero
// - capability b bit 6 shows irq level
// - dma cycles are never claimed
// - all queue modes share one 16-byte queue
// - mode held in extended control bits 7..5
`timescale 1ns/1ps
`include "ecppr_defs.svh"
module ecppr_regs (
   input  wire logic               clk,         // 100 MHz clock
   input  wire logic               nrst,        // async reset, active low
   input  wire logic [12:0]        address,     // avalon byte address
   input  wire logic               read,        // avalon read
   input  wire logic               write,       // avalon write
   input  wire logic [31:0]        writedata,   // avalon write data
   output logic      [31:0]        readdata,    // avalon read data
   output logic                    waitrequest, // avalon wait
   input  wire logic               address_enable_qual, // high: dma cycle
   input  wire logic [2:0]         irq_select,  // irq field for cap b
   input  wire logic [2:0]         dma_select,  // dma field for cap b
   input  wire ecppr_pkg::ecppr_stat_s stat_in, // peripheral status pins
   input  wire logic [7:0]         port_data_in,    // data line levels
   output logic      [7:0]         port_data_out,   // data line drive
   output logic                    port_data_oe_n,  // low: drive lines
   output ecppr_pkg::ecppr_ctl_s   ctl_out,     // printer control pins
   output logic                    irq_out      // interrupt request pulse
);
   import ecppr_pkg::*;

   logic [12:0]       sync_q;
   ecppr_stat_s       st;
   logic [7:0]        pd_s;
   logic [7:0]        data_q;
   logic [5:0]        dcr_q;
   ecppr_mode_e       mode_q;
   logic              errie_q;
   logic              dma_enable_bit_q;
   logic              svc_q;
   logic [7:0]        last_rd_q;
   logic              ack_prev_q;
   logic [7:0]        rdata_d;
   ecppr_tx_e         tx_q;
   ecppr_tx_e         tx_d;
   logic [8:0]        tx_byte_q;
   logic [7:0]        cnt_q;
   logic [7:0]        cnt_d;
   logic [7:0]        pd_out_d;
   logic              pd_oe_n_d;
   ecppr_ctl_s        ctl_d;
   logic [10:0]       idx;
   logic              claim;
   logic              hit_data;
   logic              hit_stat;
   logic              hit_ctl;
   logic              hit_q;
   logic              hit_capb;
   logic              hit_ecr;
   logic              acc;
   logic              wr_en;
   logic              rd_en;
   logic              q_mode;
   logic              fwd_mode;
   logic              dir_eff;
   logic              q_clr;
   logic              push_host;
   logic              push_rev;
   logic              pop_host;
   logic              pop_tx;
   logic              f_push;
   logic              f_pop;
   logic [8:0]        f_din;
   logic [8:0]        f_head;
   logic              f_full;
   logic              f_empty;
   logic [4:0]        f_cnt;
   logic              ack_rise;
   logic              ack_fall;
   logic              svc_cond;
   logic [7:0]        cnt_load;

   // pins cross into the clock domain first
   ecppr_sync #(.W(13)) u_sync (
      .clk  (clk),
      .nrst (nrst),
      .d    ({port_data_in, stat_in ^ 5'h02}), // ack kept inverted
      .q    (sync_q)
   );
   // ack idles high; inverting it lets the cleared sync match idle level
   assign st   = ecppr_stat_s'(sync_q[4:0] ^ 5'h02);
   assign pd_s = sync_q[12:5];

   // one queue for every queue mode
   ecppr_fifo u_fifo (
      .clk   (clk),
      .nrst  (nrst),
      .clr   (q_clr),
      .push  (f_push),
      .din   (f_din),
      .pop   (f_pop),
      .dout  (f_head),
      .full  (f_full),
      .empty (f_empty),
      .count (f_cnt)
   );

   // address decode, never claimed during a dma cycle
   assign idx      = address[12:2];
   assign claim    = ~address_enable_qual;
   assign hit_data = claim & (idx == `ECPPR_IDX_DATA);
   assign hit_stat = claim & (idx == `ECPPR_IDX_STATUS);
   assign hit_ctl  = claim & (idx == `ECPPR_IDX_CONTROL);
   assign hit_q    = claim & (idx == `ECPPR_IDX_QUEUE);
   assign hit_capb = claim & (idx == `ECPPR_IDX_CAPB);
   assign hit_ecr  = claim & (idx == `ECPPR_IDX_ECR);

   // an access completes on the edge that sees waitrequest low
   assign acc   = ~waitrequest;
   assign wr_en = write & acc;
   assign rd_en = read & acc;

   // mode qualifiers
   assign q_mode   = (mode_q == mode_compat_queue_port) | (mode_q == mode_ecp)
                   | (mode_q == mode_test);
   assign dir_eff  = dcr_q[`ECPPR_CTL_DIR]
                   & (mode_q != mode_compat)
                   & (mode_q != mode_compat_queue_port);
   assign fwd_mode = ((mode_q == mode_compat_queue_port) | (mode_q == mode_ecp))
                   & ~dir_eff;
   assign q_clr    = ~q_mode;

   // queue traffic from host, reverse capture and transmitter
   assign push_host = wr_en & ~f_full
                    & ((hit_q & q_mode)
                    | (hit_data & (mode_q == mode_ecp)));
   assign push_rev  = (mode_q == mode_ecp) & dir_eff & ack_fall
                    & ~push_host;
   assign f_push    = push_host | push_rev;
   assign f_din     = push_host ? {hit_data, writedata[7:0]}
                                : {st.busy_in, pd_s};
   assign pop_host  = rd_en & hit_q & ~f_empty
                    & ((mode_q == mode_ecp) | (mode_q == mode_test));
   assign pop_tx    = (tx_q == tx_idle) & fwd_mode & ~f_empty
                    & ~st.busy_in & ~pop_host;
   assign f_pop     = pop_host | pop_tx;

   // acknowledge edges
   assign ack_rise = st.peripheral_ack_n & ~ack_prev_q;
   assign ack_fall = ~st.peripheral_ack_n & ack_prev_q;

   // service condition on free space or fill level
   assign svc_cond = q_mode & ~dma_enable_bit_q
                   & (dir_eff ? (f_cnt >= `ECPPR_FILL_LEVEL)
                              : ((5'h10 - f_cnt) >= `ECPPR_FREE_LEVEL));

   // read value, captured in the request cycle
   always_comb begin
      rdata_d = 8'h00;
      if (hit_data) begin
         if ((mode_q == mode_compat) | (mode_q == mode_bidir))
            rdata_d = pd_s;
      end else if (hit_stat) begin
         rdata_d = {~st.busy_in, st.peripheral_ack_n,
                    st.paper_error_in, st.select_in,
                    st.peripheral_fault_n, 3'h0};
      end else if (hit_ctl) begin
         rdata_d = {2'h0, dcr_q};
      end else if (hit_q) begin
         if (mode_q == mode_config)
            rdata_d = `ECPPR_CAPA_VAL;
         else if (q_mode)
            rdata_d = f_empty ? last_rd_q : f_head[7:0];
      end else if (hit_capb) begin
         if (mode_q == mode_config)
            rdata_d = {1'b0, irq_out,
                       irq_select, dma_select};
      end else if (hit_ecr) begin
         rdata_d = {mode_q, errie_q, dma_enable_bit_q, svc_q,
                    f_full, f_empty};
      end
   end

   // bus handshake: one wait cycle, then the completing cycle
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
         readdata    <= 32'h0000_0000;
      end else if ((read | write) & waitrequest) begin
         waitrequest <= 1'b0;
         readdata    <= {24'h00_0000, rdata_d};
      end else begin
         waitrequest <= 1'b1;
      end
   end

   // host-written registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         data_q  <= `ECPPR_DATA_RST;
         dcr_q   <= `ECPPR_CTL_RST;
         mode_q  <= ecppr_mode_e'(3'(`ECPPR_ECR_RST >> `ECPPR_ECR_MODE_LO));
         errie_q <= 1'(`ECPPR_ECR_RST >> `ECPPR_ECR_ERRIE);
         dma_enable_bit_q <= 1'(`ECPPR_ECR_RST >> `ECPPR_ECR_DMA_ENABLE_BIT);
      end else begin
         if (wr_en & hit_data & ~q_mode)
            data_q <= writedata[7:0];
         if (wr_en & hit_ctl)
            dcr_q  <= writedata[5:0];
         if (wr_en & hit_ecr) begin
            mode_q  <= ecppr_mode_e'(writedata[`ECPPR_ECR_MODE_HI:
                                               `ECPPR_ECR_MODE_LO]);
            errie_q <= writedata[`ECPPR_ECR_ERRIE];
            dma_enable_bit_q <= writedata[`ECPPR_ECR_DMA_ENABLE_BIT];
         end
      end
   end

   // service flag: hardware set wins over a software clear
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         svc_q <= 1'(`ECPPR_ECR_RST >> `ECPPR_ECR_SVC);
      end else if (svc_cond) begin
         svc_q <= 1'b1;
      end else if (wr_en & hit_ecr) begin
         svc_q <= writedata[`ECPPR_ECR_SVC];
      end
   end

   // interrupt pulse, last byte read and ack history
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         irq_out    <= 1'b0;
         last_rd_q  <= 8'h00;
         ack_prev_q <= 1'b1;
      end else begin
         irq_out    <= (dcr_q[`ECPPR_CTL_ACKIE] & ack_rise)
                     | (svc_cond & ~svc_q);
         ack_prev_q <= st.peripheral_ack_n;
         if (pop_host)
            last_rd_q <= f_head[7:0];
      end
   end

   // forward transmit sequencer
   assign cnt_load = 8'(`ECPPR_PHASE_CYC - 1);
   always_comb begin
      tx_d  = tx_q;
      cnt_d = (cnt_q == 8'h00) ? 8'h00 : cnt_q - 8'h01;
      case (tx_q)
         tx_idle: begin
            cnt_d = cnt_load;
            if (pop_tx) tx_d = tx_setup;
         end
         tx_setup: begin
            if (cnt_q == 8'h00) begin
               tx_d  = tx_strobe;
               cnt_d = cnt_load;
            end
         end
         tx_strobe: begin
            if (cnt_q == 8'h00) begin
               tx_d  = tx_hold;
               cnt_d = cnt_load;
            end
         end
         tx_hold: begin
            if (cnt_q == 8'h00) tx_d = tx_idle;
         end
         default: tx_d = tx_idle;
      endcase
      if (~fwd_mode) tx_d = tx_idle;
   end

   // sequencer state
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         tx_q      <= tx_idle;
         cnt_q     <= 8'h00;
         tx_byte_q <= 9'h000;
      end else begin
         tx_q  <= tx_d;
         cnt_q <= cnt_d;
         if (pop_tx) tx_byte_q <= f_head;
      end
   end

   // pin values by mode
   always_comb begin
      pd_out_d  = data_q;
      pd_oe_n_d = dir_eff;
      ctl_d.strobe_out_n         = ~dcr_q[`ECPPR_CTL_STROBE];
      ctl_d.line_feed_out_n      = ~dcr_q[`ECPPR_CTL_FEED];
      ctl_d.printer_reset_out_n  = dcr_q[`ECPPR_CTL_INIT];
      ctl_d.select_request_out_n = ~dcr_q[`ECPPR_CTL_SELIN];
      case (mode_q)
         mode_compat_queue_port, mode_ecp: begin
            pd_out_d           = tx_byte_q[7:0];
            ctl_d.strobe_out_n = (tx_q != tx_strobe);
            if (mode_q == mode_ecp)
               ctl_d.line_feed_out_n = dir_eff ? f_full
                                               : ~tx_byte_q[8];
         end
         mode_test: begin
            pd_out_d = f_head[7:0];
         end
         mode_rsvd: begin
            pd_oe_n_d             = 1'b1;
            ctl_d.strobe_out_n    = 1'b1;
            ctl_d.line_feed_out_n = 1'b1;
         end
         default: begin
            pd_out_d = data_q;
         end
      endcase
   end

   // registered pin drive
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         port_data_out  <= 8'h00;
         port_data_oe_n <= 1'b0;
         ctl_out        <= 4'hD;
      end else begin
         port_data_out  <= pd_out_d;
         port_data_oe_n <= pd_oe_n_d;
         ctl_out        <= ctl_d;
      end
   end
endmodule : ecppr_regs

// file: testbench/ecppr_regs_checker.sv
// bus and pin assertions for the port register bank
`timescale 1ns/1ps
module ecppr_regs_checker (
   input wire logic                  clk,                 // clock
   input wire logic                  nrst,                // reset, low
   input wire logic [12:0]           address,             // byte address
   input wire logic                  read,                // bus read
   input wire logic                  write,               // bus write
   input wire logic [31:0]           writedata,           // write data
   input wire logic [31:0]           readdata,            // read data
   input wire logic                  waitrequest,         // bus wait
   input wire logic                  address_enable_qual, // dma cycle
   input wire logic [7:0]            port_data_out,       // data drive
   input wire logic                  port_data_oe_n,      // low: drive
   input wire ecppr_pkg::ecppr_ctl_s ctl_out,             // control pins
   input wire logic                  irq_out              // irq pulse
);
   import ecppr_pkg::*;
   logic [2:0] mode_q;
   logic [7:0] wd_p1_q;
   logic [7:0] wd_p2_q;
   // decode of the access completing in this cycle
   wire [10:0] idx = address[12:2];
   wire        acc = !waitrequest && !address_enable_qual;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // shadow of the mode field and delayed write byte
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         mode_q  <= 3'h0;
         wd_p1_q <= 8'h00;
         wd_p2_q <= 8'h00;
      end else begin
         if (write && acc && idx == 11'h402) mode_q <= writedata[7:5];
         wd_p1_q <= writedata[7:0];
         wd_p2_q <= wd_p1_q;
      end
   end
   wait_one_a:
      assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer missing");
   wait_pulse_a:
      assert property ($fell(waitrequest) |=> waitrequest)
      else $error("wait low too long");
   stat_low_a:
      assert property (read && acc && idx == 11'h001 |-> readdata[2:0] == 3'h0)
      else $error("status low bits set");
   ctl_rd_a:
      assert property (read && acc && idx == 11'h002 |-> readdata[7:6] == 2'h0)
      else $error("control top bits set");
   dma_free_a:
      assert property (read && !waitrequest && address_enable_qual
         |-> readdata == 32'h0)
      else $error("dma cycle claimed");
   cap_a_val_a:
      assert property (read && acc && idx == 11'h400 && mode_q == 3'h7
         |-> readdata == 32'h10)
      else $error("capability a wrong");
   ctl_map_a:
      assert property (write && acc && idx == 11'h002 && mode_q[2:1] == 2'h0
         |-> ##2 ctl_out == {~wd_p2_q[0], ~wd_p2_q[1], wd_p2_q[2], ~wd_p2_q[3]})
      else $error("control pins wrong");
   data_drive_a:
      assert property (write && acc && idx == 11'h000 && mode_q == 3'h0
         |-> ##2 port_data_out == wd_p2_q && !port_data_oe_n)
      else $error("data lines wrong");
   irq_pulse_a:
      assert property (irq_out |=> !irq_out)
      else $error("irq not a pulse");
endmodule : ecppr_regs_checker

// file: testbench/ecppr_printer.sv
// printer model: latches strobed bytes and answers with an ack pulse
`timescale 1ns/1ps
module ecppr_printer (
   input wire logic                   clk,            // clock
   input wire logic [7:0]             port_data_out,  // device drive
   input wire logic                   port_data_oe_n, // low: device drives
   input wire ecppr_pkg::ecppr_ctl_s  ctl_out,        // control pins
   input wire logic [7:0]             drive_val,      // our byte on lines
   input wire logic [3:0]             pins,           // fault,sel,paper,busy
   output ecppr_pkg::ecppr_stat_s     stat_in,        // status pins
   output logic [7:0]                 port_data_in,   // line level
   output logic [7:0]                 got_byte,       // last strobed byte
   output logic                       got_feed,       // feed at strobe
   output int                         got_cnt         // strobes seen
);
   import ecppr_pkg::*;
   logic strobe_q = 1'b1;
   logic ack_n = 1'b1;
   int   ack_t = 0;
   initial got_cnt = 0;
   // line level from whichever side drives
   assign port_data_in = port_data_oe_n ? drive_val : port_data_out;
   assign stat_in = {pins[3], pins[2], pins[1], ack_n, pins[0]};
   // latch on strobe fall, ack low pulse then rise after strobe release
   always @(posedge clk) begin
      strobe_q <= ctl_out.strobe_out_n;
      if (strobe_q && !ctl_out.strobe_out_n) begin
         got_byte <= port_data_in;
         got_feed <= ctl_out.line_feed_out_n;
         got_cnt  <= got_cnt + 1;
      end
      if (!strobe_q && ctl_out.strobe_out_n) ack_t <= 8;
      else if (ack_t > 0) ack_t <= ack_t - 1;
      ack_n <= !(ack_t > 0 && ack_t < 5);
   end
endmodule : ecppr_printer

// file: testbench/ecppr_regs_tb.sv
// self-checking bench for the parallel port register bank
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_fail++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module ecppr_regs_tb;
   import ecppr_pkg::*;
   logic        clk = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
   logic        aeq = 1'b0, waitrequest, port_data_oe_n, irq_out, got_feed;
   logic [12:0] address = 13'h0000;
   logic [31:0] writedata = 32'h0, readdata;
   logic [7:0]  port_data_in, port_data_out, got_byte, rv;
   logic [7:0]  drive_val = 8'hC3;
   logic [3:0]  pins = 4'hC;
   ecppr_stat_s stat_in;
   ecppr_ctl_s  ctl_out;
   int          n_fail = 0, checks = 0, irq_cnt = 0, got_cnt, k, c0;
   always #5 clk = ~clk;
   // count interrupt pulses
   always @(posedge clk) if (irq_out === 1'b1) irq_cnt <= irq_cnt + 1;
   ecppr_regs uut (.clk(clk), .nrst(nrst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .address_enable_qual(aeq),
      .irq_select(3'h5), .dma_select(3'h2), .stat_in(stat_in),
      .port_data_in(port_data_in), .port_data_out(port_data_out),
      .port_data_oe_n(port_data_oe_n), .ctl_out(ctl_out), .irq_out(irq_out));
   ecppr_printer u_prt (.clk(clk), .port_data_out(port_data_out),
      .port_data_oe_n(port_data_oe_n), .ctl_out(ctl_out),
      .drive_val(drive_val), .pins(pins), .stat_in(stat_in),
      .port_data_in(port_data_in), .got_byte(got_byte),
      .got_feed(got_feed), .got_cnt(got_cnt));
   task end_sim;
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : end_sim
   // one bus access held until waitrequest is seen low
   task automatic bus(input logic rd, input logic [10:0] ix,
                      input logic [7:0] wd, input logic q);
      int n;
      @(posedge clk);
      read <= rd; write <= !rd; aeq <= q;
      address <= {ix, 2'b00}; writedata <= {24'h0, wd};
      n = 0;
      do begin @(posedge clk); n++; end
      while (waitrequest !== 1'b0 && n < 50);
      if (waitrequest !== 1'b0) begin n_fail++; end_sim(); end
      rv = readdata[7:0];
      read <= 1'b0; write <= 1'b0; aeq <= 1'b0;
   endtask : bus
   task wr(input logic [10:0] ix, input logic [7:0] wd);
      bus(1'b0, ix, wd, 1'b0);
   endtask : wr
   task rd(input logic [10:0] ix);
      bus(1'b1, ix, 8'h00, 1'b0);
   endtask : rd
   task set_mode(input logic [2:0] m);
      wr(11'h402, {m, 5'h14});
   endtask : set_mode
   task wait_got;
      int n;
      n = 0;
      while (got_cnt == c0 && n < 1000) begin @(posedge clk); n++; end
      if (got_cnt == c0) begin n_fail++; end_sim(); end
   endtask : wait_got
   task t_reset;
      rd(11'h000); `CHK("data", 8'h00, rv)
      rd(11'h002); `CHK("control", 8'h00, rv)
      rd(11'h402); `CHK("ecr", 8'h15, rv)
      `CHK("ctl pins", 4'hD, ctl_out)
   endtask : t_reset
   task t_data;
      wr(11'h000, 8'hA5);
      repeat (2) @(posedge clk);
      `CHK("lines", 8'hA5, port_data_out)
      set_mode(3'h1);
      wr(11'h002, 8'h20);
      repeat (4) @(posedge clk);
      `CHK("oe_n", 1'b1, port_data_oe_n)
      rd(11'h000); `CHK("line read", 8'hC3, rv)
      wr(11'h002, 8'h00);
      set_mode(3'h0);
      bus(1'b0, 11'h000, 8'h77, 1'b1);
      bus(1'b1, 11'h000, 8'h00, 1'b1); `CHK("dma rd", 8'h00, rv)
      rd(11'h000); `CHK("data kept", 8'hA5, rv)
   endtask : t_data
   task t_status;
      for (k = 0; k < 16; k++) begin
         pins <= k[3:0];
         repeat (4) @(posedge clk);
         rd(11'h001);
         `CHK("status", {~pins[0], 1'b1, pins[1], pins[2], pins[3], 3'h0}, rv)
      end
      pins <= 4'hC;
   endtask : t_status
   task t_control;
      c0 = irq_cnt;
      set_mode(3'h1);
      wr(11'h002, 8'hFF);
      set_mode(3'h0);
      rd(11'h002); `CHK("control", 8'h3F, rv)
      `CHK("ctl pins", 4'h2, ctl_out)
      `CHK("oe_n", 1'b0, port_data_oe_n)
      set_mode(3'h1);
      wr(11'h002, 8'h00);
      repeat (30) @(posedge clk);
      `CHK("no irq", c0, irq_cnt)
      wr(11'h002, 8'h11);
      wr(11'h002, 8'h10);
      for (k = 0; k < 100 && irq_cnt == c0; k++) @(posedge clk);
      `CHK("ack irq", c0 + 1, irq_cnt)
      wr(11'h002, 8'h00);
   endtask : t_control
   task t_modes;
      for (k = 0; k < 8; k++) begin
         set_mode(k[2:0]);
         rd(11'h402); `CHK("mode", k[2:0], rv[7:5])
         if (k == 5) begin
            `CHK("rsvd oe_n", 1'b1, port_data_oe_n)
            `CHK("rsvd strobe", 1'b1, ctl_out.strobe_out_n)
         end
         set_mode(3'h0);
      end
   endtask : t_modes
   task t_test;
      set_mode(3'h6);
      for (k = 0; k < 17; k++) wr(11'h400, 8'h40 + k[7:0]);
      `CHK("test lines", 8'h40, port_data_out)
      wr(11'h402, 8'hD0);
      rd(11'h402); `CHK("full", 8'hD2, rv)
      for (k = 0; k < 16; k++) begin
         rd(11'h400); `CHK("fifo", 8'h40 + k[7:0], rv)
      end
      rd(11'h402); `CHK("empty", 8'hD5, rv)
      rd(11'h400); `CHK("reread", 8'h4F, rv)
      set_mode(3'h0);
      set_mode(3'h7);
      rd(11'h400); `CHK("cap a", 8'h10, rv)
      rd(11'h401); `CHK("cap b", 8'h2A, rv)
      set_mode(3'h0);
   endtask : t_test
   task t_send;
      c0 = got_cnt;
      set_mode(3'h2);
      wr(11'h400, 8'h5A);
      wait_got(); `CHK("compat byte", 8'h5A, got_byte)
      repeat (120) @(posedge clk);
      set_mode(3'h0);
      set_mode(3'h3);
      c0 = got_cnt;
      wr(11'h000, 8'h21);
      wait_got(); `CHK("addr byte", 8'h21, got_byte)
      `CHK("addr tag", 1'b0, got_feed)
      repeat (120) @(posedge clk);
      c0 = got_cnt;
      wr(11'h400, 8'h33);
      wait_got(); `CHK("ecp byte", 8'h33, got_byte)
      `CHK("data tag", 1'b1, got_feed)
      repeat (120) @(posedge clk);
      set_mode(3'h0);
   endtask : t_send
   // reset, then run every scenario in turn
   initial begin
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_data();
      t_status();
      t_control();
      t_modes();
      t_test();
      t_send();
      end_sim();
   end
endmodule : ecppr_regs_tb
bind ecppr_regs ecppr_regs_checker u_chk (.clk(clk), .nrst(nrst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest),
   .address_enable_qual(address_enable_qual), .port_data_out(port_data_out),
   .port_data_oe_n(port_data_oe_n), .ctl_out(ctl_out), .irq_out(irq_out));
